// File: shared/fsp_pkg.sv
package fsp_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [15:0] ADDR_CTRL    = 16'hc070;
  localparam logic [15:0] ADDR_GAP     = 16'hc074;
  localparam logic [15:0] ADDR_BAUD    = 16'hc078;
  localparam logic [15:0] ADDR_TXDATA  = 16'hc07c;
  localparam logic [15:0] ADDR_RXDATA  = 16'hc080;
  localparam logic [15:0] ADDR_STATUS  = 16'hc084;
  localparam logic [15:0] ADDR_INTSTAT = 16'hc088;
  localparam logic [15:0] ADDR_INTMASK = 16'hc08c;
  localparam logic [15:0] ADDR_BLKADDR = 16'hc090;

  // Control fields
  localparam int CTRL_TX_BLOCK = 0;
  localparam int CTRL_RX_BLOCK = 1;
  localparam int CTRL_HS_EN    = 2;
  localparam int CTRL_W        = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status fields
  localparam int STAT_RX_READY = 0;
  localparam int STAT_TX_BUSY  = 1;
  localparam int STAT_TX_FULL  = 2;

  // Interrupt status and mask fields
  localparam int INT_RX_BYTE  = 0;
  localparam int INT_TX_DONE  = 1;
  localparam int INT_FRAME    = 2;
  localparam int INT_OVERFLOW = 3;
  localparam int INT_W        = 4;
  localparam logic [3:0] INT_RESET = 4'h0;

  // Gap, baud and block address settings
  localparam logic [15:0] GAP_RESET    = 16'h000b;
  localparam logic [15:0] GAP_OVERHEAD = 16'h0009;
  localparam logic [15:0] BAUD_RESET   = 16'h0068;
  localparam logic [15:0] BLK_RESET    = 16'h0000;

  // Frame and buffer shape
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_RTS   = 3'b001,
    TX_START = 3'b010,
    TX_DATA  = 3'b011,
    TX_STOP  = 3'b100
  } fsp_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } fsp_rx_state_t;
endpackage

// File: hdl/fsp_fifo.sv
module fsp_fifo
  import fsp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       wrValid,
  output logic            wrReady,
  input  wire logic [7:0] wrData,
  output logic            rdValid,
  input  wire logic       rdReady,
  output logic      [7:0] rdData
);
  import fsp_pkg::*;

  logic [7:0]         mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wrPtr_r;
  logic [FIFO_AW-1:0] rdPtr_r;
  logic [FIFO_AW:0]   count_r;
  wire                push;
  wire                pop;

  // Full and empty straight from the occupancy count
  assign wrReady = (count_r != FIFO_DEPTH[FIFO_AW:0]);
  assign rdValid = (count_r != '0);
  assign rdData  = mem[rdPtr_r];
  assign push    = wrValid && wrReady;
  assign pop     = rdValid && rdReady;

  // Storage has no reset; only pointers and the count carry state
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  // Pointer and count update
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + {{FIFO_AW{1'b0}}, push} - {{FIFO_AW{1'b0}}, pop};
    end
  end
endmodule

// File: hdl/fsp_rx.sv
module fsp_rx
  import fsp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        serialRxLine,
  input  wire logic [15:0] baudDivisor,
  output logic             rxValid,
  output logic       [7:0] rxData,
  output logic             frameError
);
  import fsp_pkg::*;

  fsp_rx_state_t rxState_r;
  logic          rxMeta_r;
  logic          rxSync_r;
  logic          rxPrev_r;
  logic [15:0]   cnt_r;
  logic [2:0]    bitIdx_r;
  logic [7:0]    shift_r;
  wire           bitEnd;
  wire           halfEnd;

  // Sampling mid-bit keeps a few percent of rate error inside the eye
  assign bitEnd  = (cnt_r == baudDivisor - 16'h0001);
  assign halfEnd = (cnt_r == {1'b0, baudDivisor[15:1]});

  // Line is asynchronous, so two flops before anything looks at it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= serialRxLine;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  // Frame receiver, LSB arrives first, high line is a one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxState_r  <= RX_IDLE;
      cnt_r      <= '0;
      bitIdx_r   <= '0;
      shift_r    <= '0;
      rxValid    <= 1'b0;
      rxData     <= '0;
      frameError <= 1'b0;
    end else begin
      rxValid    <= 1'b0;
      frameError <= 1'b0;
      cnt_r      <= cnt_r + 16'h0001;
      case (rxState_r)
        RX_IDLE: begin
          cnt_r <= '0;
          if (rxPrev_r && !rxSync_r) rxState_r <= RX_START;
        end
        RX_START: begin
          if (halfEnd) begin
            cnt_r     <= '0;
            bitIdx_r  <= '0;
            rxState_r <= rxSync_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bitEnd) begin
            cnt_r    <= '0;
            shift_r  <= {rxSync_r, shift_r[7:1]};
            bitIdx_r <= bitIdx_r + 3'd1;
            if (bitIdx_r == 3'd7) rxState_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bitEnd) begin
            rxValid    <= rxSync_r;
            rxData     <= shift_r;
            frameError <= !rxSync_r;
            rxState_r  <= RX_IDLE;
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end
endmodule

// File: hdl/fsp_serial_port.sv
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Bit 0 of every byte is the least significant and goes first on both lines.
// - A high line level is a one data bit on transmit and receive.
// - One bit period is the programmed baud divisor in clocks, used for every bit.
// - Block transmit frames bytes as byte mode does, only the stop time differs.
// - In block transmit the stop bit lasts the gap value minus nine bit periods, or one bit period when the gap is nine or less.
// - The gap reset value gives a block stop bit of two bit periods.
// - The receiver takes asynchronous data and tolerates rate error by mid-bit sampling.
// - Byte receive puts bytes in a FIFO and the ready flag is its not-empty state.
// - Block receive writes each byte to memory instead of the FIFO.
// - With handshake on, the start bit waits while clear-to-send is low.
// - Request-to-send drops during the third data bit of the byte.
module fsp_serial_port
  import fsp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             serial_tx_line,
  input  wire logic        serial_rx_line,
  input  wire logic        clear_to_send_input,
  output logic             request_to_send_output,
  output logic             rx_ready_flag,
  output logic             memWrEn,
  output logic      [15:0] memWrAddr,
  output logic      [7:0]  memWrData,
  output logic             irq
);
  import fsp_pkg::*;

  function automatic logic isMapped(input logic [15:0] a);
    isMapped = (a == ADDR_CTRL) || (a == ADDR_GAP) || (a == ADDR_BAUD) ||
               (a == ADDR_TXDATA) || (a == ADDR_RXDATA) || (a == ADDR_STATUS) ||
               (a == ADDR_INTSTAT) || (a == ADDR_INTMASK) || (a == ADDR_BLKADDR);
  endfunction

  logic [CTRL_W-1:0] ctrl_r;
  logic [15:0]       gap_r;
  logic [15:0]       baud_r;
  logic [7:0]        txHold_r;
  logic              txHoldValid_r;
  logic [INT_W-1:0]  intStat_r;
  logic [INT_W-1:0]  intMask_r;
  logic [INT_W-1:0]  intStat_nxt;
  fsp_tx_state_t     txState_r;
  logic [15:0]       baudCnt_r;
  logic [2:0]        bitIdx_r;
  logic [7:0]        txShift_r;
  logic [15:0]       stopLeft_r;
  logic              txDone_r;
  wire               rxValid;
  wire [7:0]         rxData;
  wire               frameError;
  wire               fifoWrReady;
  wire               fifoValid;
  wire [7:0]         fifoData;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, read data captured in the setup cycle
  wire        setupPh  = psel && !penable;
  wire        accessPh = psel && penable;
  wire        wrAcc    = accessPh && pwrite && isMapped(paddr);
  wire        rdAcc    = accessPh && !pwrite;
  wire        wrCtrl   = wrAcc && (paddr == ADDR_CTRL);
  wire        wrGap    = wrAcc && (paddr == ADDR_GAP);
  wire        wrBaud   = wrAcc && (paddr == ADDR_BAUD);
  wire        wrTx     = wrAcc && (paddr == ADDR_TXDATA);
  wire        wrInt    = wrAcc && (paddr == ADDR_INTSTAT);
  wire        wrMask   = wrAcc && (paddr == ADDR_INTMASK);
  wire        wrBlk    = wrAcc && (paddr == ADDR_BLKADDR);
  wire        rdPop    = rdAcc && (paddr == ADDR_RXDATA);
  wire        txBlock  = ctrl_r[CTRL_TX_BLOCK];
  wire        rxBlock  = ctrl_r[CTRL_RX_BLOCK];
  wire        hsEn     = ctrl_r[CTRL_HS_EN];
  wire        txBusy   = (txState_r != TX_IDLE);
  wire [2:0]  statusW  = {txHoldValid_r, txBusy, fifoValid};
  wire [31:0] rdMux    =
      (paddr == ADDR_CTRL)    ? {29'h0, ctrl_r} :
      (paddr == ADDR_GAP)     ? {16'h0, gap_r} :
      (paddr == ADDR_BAUD)    ? {16'h0, baud_r} :
      (paddr == ADDR_RXDATA)  ? {24'h0, fifoValid ? fifoData : 8'h00} :
      (paddr == ADDR_STATUS)  ? {29'h0, statusW} :
      (paddr == ADDR_INTSTAT) ? {28'h0, intStat_r} :
      (paddr == ADDR_INTMASK) ? {28'h0, intMask_r} :
      (paddr == ADDR_BLKADDR) ? {16'h0, memWrAddr} : 32'h0;

  assign pready  = accessPh;
  assign pslverr = accessPh && !isMapped(paddr);

  // Read data is registered so it is stable through the access cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) prdata <= '0;
    else if (setupPh && !pwrite) prdata <= rdMux;
  end

  // Software settings
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r    <= CTRL_RESET;
      gap_r     <= GAP_RESET;
      baud_r    <= BAUD_RESET;
      intMask_r <= INT_RESET;
    end else begin
      if (wrCtrl) ctrl_r <= pwdata[CTRL_W-1:0];
      if (wrGap) gap_r <= pwdata[15:0];
      if (wrBaud) baud_r <= (pwdata[15:0] == 16'h0) ? 16'h0001 : pwdata[15:0];
      if (wrMask) intMask_r <= pwdata[INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit holding register; a write while full is dropped, status shows it
  wire txLoad = (txState_r == TX_IDLE) && txHoldValid_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txHold_r      <= '0;
      txHoldValid_r <= 1'b0;
    end else if (wrTx && !txHoldValid_r) begin
      txHold_r      <= pwdata[7:0];
      txHoldValid_r <= 1'b1;
    end else if (txLoad) begin
      txHoldValid_r <= 1'b0;
    end
  end

  // Stop length; a gap of nine or less would give no stop bit, so one is kept
  wire        gapOk     = (gap_r > GAP_OVERHEAD);
  wire [15:0] stopCount = (txBlock && gapOk) ? (gap_r - GAP_OVERHEAD) : 16'h0001;
  wire        bitEnd    = (baudCnt_r == baud_r - 16'h0001);
  wire        startEnd  = (txState_r == TX_START) && bitEnd;
  wire        lastData  = (txState_r == TX_DATA) && bitEnd && (bitIdx_r == 3'd7);

  // Transmit sequencer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txState_r              <= TX_IDLE;
      baudCnt_r              <= '0;
      bitIdx_r               <= '0;
      txShift_r              <= '0;
      stopLeft_r             <= '0;
      txDone_r               <= 1'b0;
      serial_tx_line         <= 1'b1;
      request_to_send_output <= 1'b0;
    end else begin
      txDone_r  <= 1'b0;
      baudCnt_r <= bitEnd ? 16'h0000 : baudCnt_r + 16'h0001;
      case (txState_r)
        TX_IDLE: begin
          serial_tx_line <= 1'b1;
          baudCnt_r      <= '0;
          if (txLoad) begin
            txShift_r <= txHold_r;
            if (hsEn) begin
              txState_r              <= TX_RTS;
              request_to_send_output <= 1'b1;
            end else begin
              txState_r      <= TX_START;
              serial_tx_line <= 1'b0;
            end
          end
        end
        TX_RTS: begin
          baudCnt_r <= '0;
          if (clear_to_send_input) begin
            txState_r      <= TX_START;
            serial_tx_line <= 1'b0;
          end
        end
        TX_START: begin
          if (bitEnd) begin
            txState_r      <= TX_DATA;
            bitIdx_r       <= '0;
            serial_tx_line <= txShift_r[0];
          end
        end
        TX_DATA: begin
          if (bitEnd) begin
            if (bitIdx_r == 3'd1) request_to_send_output <= 1'b0;
            if (bitIdx_r == 3'd7) begin
              txState_r      <= TX_STOP;
              serial_tx_line <= 1'b1;
              stopLeft_r     <= stopCount - 16'h0001;
            end else begin
              bitIdx_r       <= bitIdx_r + 3'd1;
              txShift_r      <= {1'b0, txShift_r[7:1]};
              serial_tx_line <= txShift_r[1];
            end
          end
        end
        TX_STOP: begin
          if (bitEnd) begin
            if (stopLeft_r == 16'h0) begin
              txState_r <= TX_IDLE;
              txDone_r  <= 1'b1;
            end else begin
              stopLeft_r <= stopLeft_r - 16'h0001;
            end
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive path and its destinations
  fsp_rx u_rx (
    .clock        (clock),
    .reset_n      (reset_n),
    .serialRxLine (serial_rx_line),
    .baudDivisor  (baud_r),
    .rxValid      (rxValid),
    .rxData       (rxData),
    .frameError   (frameError)
  );

  wire fifoPush = rxValid && !rxBlock;
  wire overflow = fifoPush && !fifoWrReady;

  fsp_fifo u_fifo (
    .clock   (clock),
    .reset_n (reset_n),
    .wrValid (fifoPush),
    .wrReady (fifoWrReady),
    .wrData  (rxData),
    .rdValid (fifoValid),
    .rdReady (rdPop),
    .rdData  (fifoData)
  );

  assign rx_ready_flag = fifoValid;

  // Block receive bypasses the FIFO and walks a memory address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      memWrEn   <= 1'b0;
      memWrData <= '0;
      memWrAddr <= BLK_RESET;
    end else begin
      memWrEn <= rxValid && rxBlock;
      if (rxValid && rxBlock) memWrData <= rxData;
      if (wrBlk) memWrAddr <= pwdata[15:0];
      else if (memWrEn) memWrAddr <= memWrAddr + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event beats a write-one-to-clear in the same cycle
  wire [INT_W-1:0] events = {overflow, frameError, txDone_r, rxValid};
  wire [INT_W-1:0] w1c    = wrInt ? pwdata[INT_W-1:0] : '0;

  assign intStat_nxt = (intStat_r & ~w1c) | events;
  assign irq         = |(intStat_r & intMask_r);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) intStat_r <= INT_RESET;
    else intStat_r <= intStat_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_wait_cts;
    (txState_r == TX_RTS) && !clear_to_send_input;
  endsequence

  sequence s_last_bit;
    lastData;
  endsequence

  a_idle_line_high: assert property (
    (txState_r == TX_IDLE) |-> serial_tx_line)
    else $error("line not high while idle");

  a_start_bit_low: assert property (
    (txState_r == TX_START) |-> !serial_tx_line)
    else $error("start bit not low");

  a_cts_holds_off: assert property (
    s_wait_cts |=> (txState_r == TX_RTS) && serial_tx_line)
    else $error("start bit sent while clear-to-send low");

  a_rts_before_start: assert property (
    (txState_r == TX_IDLE) && txLoad && hsEn |=> request_to_send_output && serial_tx_line)
    else $error("request-to-send not raised ahead of start");

  a_rts_third_bit: assert property (
    (txState_r == TX_DATA) && (bitIdx_r == 3'd1) && bitEnd |=>
      !request_to_send_output && (bitIdx_r == 3'd2))
    else $error("request-to-send not dropped in third data bit");

  a_first_bit_lsb: assert property (
    startEnd |=> serial_tx_line == $past(txShift_r[0]))
    else $error("first data bit is not bit 0");

  a_stop_length: assert property (
    s_last_bit ##0 (txBlock && gapOk) |=>
      (stopLeft_r == $past(gap_r) - GAP_OVERHEAD - 16'h0001) && serial_tx_line)
    else $error("block stop length wrong");

  a_byte_stop_one: assert property (
    s_last_bit ##0 !txBlock |=> (stopLeft_r == 16'h0000) && serial_tx_line)
    else $error("byte stop not one bit period");

  a_rx_ready_set: assert property (
    fifoPush && fifoWrReady |=> rx_ready_flag)
    else $error("ready flag missing after byte");

  a_block_to_mem: assert property (
    rxValid && rxBlock |=> memWrEn && (memWrData == $past(rxData)))
    else $error("block byte not written to memory");

  a_irq_level: assert property (
    (intStat_r & intMask_r) != '0 |-> irq)
    else $error("interrupt low with unmasked event");
endmodule

// File: tb/fsp_peer.sv
module fsp_peer (
  input  wire logic clock,
  input  wire logic txLine,
  input  wire logic rtsIn,
  output logic      rxLine,
  output logic      ctsOut
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned bitLen = 4;
  int unsigned cyc = 0;
  logic        allow = 1'b1;
  logic        keep = 1'b0;
  logic [7:0]  gotQ[$];
  int unsigned startQ[$];
  logic        stopQ[$];

  initial rxLine = 1'b1;

  ////////////////////////////////////////
  // Once granted, clear-to-send stays up until request-to-send drops
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (!rtsIn) keep <= 1'b0;
    else if (ctsOut) keep <= 1'b1;
  end
  assign ctsOut = allow | keep;

  // Decoder samples mid-bit on the falling edge, away from line updates
  initial begin : dec
    logic [7:0]  d;
    int unsigned st;
    forever begin
      @(negedge txLine);
      st = cyc;
      repeat (bitLen / 2) @(negedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (bitLen) @(negedge clock);
        d[i] = txLine;
      end
      repeat (bitLen) @(negedge clock);
      stopQ.push_back(txLine);
      gotQ.push_back(d);
      startQ.push_back(st);
    end
  end

  // Sender: n cycles a bit, so the rate may differ from the divisor
  task automatic send(input logic [7:0] d, input int unsigned n, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rxLine <= f[i];
      repeat (n - 1) @(posedge clock);
    end
    @(posedge clock);
    rxLine <= 1'b1;
  endtask
endmodule

// File: tb/fsp_serial_port_tb_top.sv
module fsp_serial_port_tb_top
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txLine;
  logic        rxLine;
  logic        cts;
  logic        rts;
  logic        rxReady;
  logic        memWrEn;
  logic [15:0] memWrAddr;
  logic [7:0]  memWrData;
  logic        irq;
  logic        lastErr;
  int          fail_count = 0;
  int          checks = 0;

  always #2.5 clock = ~clock;

  fsp_serial_port DUT (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_tx_line(txLine), .serial_rx_line(rxLine),
    .clear_to_send_input(cts), .request_to_send_output(rts), .rx_ready_flag(rxReady),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData), .irq(irq));
  fsp_peer peer (.clock(clock), .txLine(txLine), .rtsIn(rts), .rxLine(rxLine), .ctsOut(cts));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // APB transfer; waits on pready, bounded so a stuck slave cannot hang
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1'b1, pready);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  task automatic clr();
    peer.gotQ.delete();
    peer.startQ.delete();
    peer.stopQ.delete();
  endtask

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (peer.gotQ.size() < n && k < 3000) begin
      @(posedge clock);
      k++;
    end
    chk("frames", n, peer.gotQ.size());
  endtask

  // Start-to-start distance; a few cycles of reload latency allowed
  function automatic logic span(input int unsigned e);
    int unsigned d;
    d = peer.startQ[1] - peer.startQ[0];
    return (d >= e && d <= e + 3);
  endfunction

  ////////////////////////////////////////
  task automatic t_reset();
    @(negedge clock);
    chk("idle tx", 1'b1, txLine);
    chk("rts reset", 1'b0, rts);
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("gap", ADDR_GAP, 32'(GAP_OVERHEAD) + 32'h2);
    rdc("baud", ADDR_BAUD, 32'h68);
    rdc("intmask", ADDR_INTMASK, 32'h0);
    rdc("unmapped", 16'hc0fc, 32'h0);
    chk("slverr", 1'b1, lastErr);
  endtask

  task automatic t_tx_byte();
    wr(ADDR_BAUD, 32'h4);
    clr();
    wr(ADDR_TXDATA, 32'ha5);
    wr(ADDR_TXDATA, 32'h3c);
    rdc("status busy", ADDR_STATUS, 32'((1 << STAT_TX_FULL) | (1 << STAT_TX_BUSY)));
    wait_frames(2);
    chk("tx byte0", 32'ha5, peer.gotQ[0]);
    chk("tx byte1", 32'h3c, peer.gotQ[1]);
    chk("tx stop", 1'b1, peer.stopQ[0]);
    chk("byte frame", 1'b1, span(10 * 4));
    repeat (8) @(posedge clock);
    rdc("tx done", ADDR_INTSTAT, 32'h2);
    wr(ADDR_INTSTAT, 32'hf);
  endtask

  // Default gap, then a wider one; frame length tracks the gap value
  task automatic t_tx_block();
    wr(ADDR_CTRL, 32'h1);
    for (int g = 0; g < 2; g++) begin
      if (g == 1) wr(ADDR_GAP, 32'he);
      clr();
      wr(ADDR_TXDATA, 32'h81);
      wr(ADDR_TXDATA, 32'h7e);
      wait_frames(2);
      chk("blk byte", 32'h81, peer.gotQ[0]);
      chk("blk gap", 1'b1, span((g == 1 ? 14 : 11) * 4));
    end
    repeat (80) @(posedge clock);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_INTSTAT, 32'hf);
  endtask

  task automatic t_hs();
    int k;
    @(posedge clock);
    peer.allow <= 1'b0;
    wr(ADDR_CTRL, 32'h4);
    clr();
    wr(ADDR_TXDATA, 32'h5c);
    repeat (20) @(negedge clock);
    chk("rts up", 1'b1, rts);
    chk("tx held", 1'b1, txLine);
    @(posedge clock);
    peer.allow <= 1'b1;
    k = 0;
    while (txLine !== 1'b0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    repeat (8) @(negedge clock);
    chk("rts bit1", 1'b1, rts);
    repeat (6) @(negedge clock);
    chk("rts bit2", 1'b0, rts);
    wait_frames(1);
    chk("hs byte", 32'h5c, peer.gotQ[0]);
    repeat (40) @(posedge clock);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_INTSTAT, 32'hf);
  endtask

  // Off-rate bytes, masking, then a bad stop bit
  task automatic t_rx_byte();
    wr(ADDR_BAUD, 32'h18);
    wr(ADDR_INTMASK, 32'h1);
    peer.send(8'h96, 25, 1'b1);
    peer.send(8'h5a, 23, 1'b1);
    repeat (30) @(negedge clock);
    chk("rx ready", 1'b1, rxReady);
    chk("irq on", 1'b1, irq);
    wr(ADDR_INTMASK, 32'h0);
    @(negedge clock);
    chk("irq masked", 1'b0, irq);
    rdc("rx byte0", ADDR_RXDATA, 32'h96);
    rdc("rx byte1", ADDR_RXDATA, 32'h5a);
    @(negedge clock);
    chk("rx empty", 1'b0, rxReady);
    peer.send(8'hff, 24, 1'b0);
    repeat (30) @(negedge clock);
    rdc("err stat", ADDR_INTSTAT, 32'h5);
    chk("err dropped", 1'b0, rxReady);
    wr(ADDR_INTSTAT, 32'h5);
    rdc("stat clear", ADDR_INTSTAT, 32'h0);
  endtask

  task automatic t_rx_block();
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_BLKADDR, 32'h100);
    for (int i = 0; i < 2; i++) begin
      fork
        peer.send(8'h70 + 8'(i), 24, 1'b1);
        begin
          for (int k = 0; k < 400 && memWrEn !== 1'b1; k++) @(negedge clock);
          chk("blk addr", 32'h100 + 32'(i), memWrAddr);
          chk("blk data", 32'h70 + 32'(i), memWrData);
        end
      join
    end
    chk("no fifo", 1'b0, rxReady);
  endtask

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_tx_byte();
    t_tx_block();
    t_hs();
    t_rx_byte();
    t_rx_block();
    print_verdict();
  end

  // Watchdog, well beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
endmodule
